// File: inc/mpbu_pkg.sv
// shared constants and types of the motion profile and backlash unit
package mpbu_pkg;

  // -----------------------------------------------------------------
  // register map (byte addresses)
  // -----------------------------------------------------------------
  localparam logic [7:0] ADDR_CMD     = 8'h00;
  localparam logic [7:0] ADDR_DELTA   = 8'h04;
  localparam logic [7:0] ADDR_TARGET  = 8'h08;
  localparam logic [7:0] ADDR_SPEED   = 8'h0c;
  localparam logic [7:0] ADDR_ACCEL   = 8'h10;
  localparam logic [7:0] ADDR_DECEL   = 8'h14;
  localparam logic [7:0] ADDR_MAXSPD  = 8'h18;
  localparam logic [7:0] ADDR_PLAYSPD = 8'h1c;
  localparam logic [7:0] ADDR_PLAYDST = 8'h20;
  localparam logic [7:0] ADDR_CTRL    = 8'h24;
  localparam logic [7:0] ADDR_STATUS  = 8'h28;
  localparam logic [7:0] ADDR_POS     = 8'h2c;
  localparam logic [7:0] ADDR_CURSPD  = 8'h30;
  localparam logic [7:0] ADDR_LIMCFG  = 8'h34;

  // command codes written to ADDR_CMD
  localparam logic [2:0] CMD_ABS_MOVE  = 3'h1;
  localparam logic [2:0] CMD_REL_MOVE  = 3'h2;
  localparam logic [2:0] CMD_SOFT_HALT = 3'h3;
  localparam logic [2:0] CMD_STOP      = 3'h4;
  localparam logic [2:0] CMD_PLAY_TAKE = 3'h5;
  localparam logic [2:0] CMD_RUN_RIGHT = 3'h6;
  localparam logic [2:0] CMD_RUN_LEFT  = 3'h7;

  // control register fields
  localparam int CTRL_ACCEL_EN = 0;
  localparam int CTRL_PLAY_EN  = 1;
  localparam int CTRL_REVERSE  = 2;
  localparam int CTRL_MAX_EN   = 3;
  localparam logic [3:0] CTRL_RESET = 4'h1;

  // status register fields
  localparam int STS_MOVING   = 0;
  localparam int STS_PLAY     = 1;
  localparam int STS_BAD_VAL  = 2;
  localparam int STS_CONT     = 3;

  // -----------------------------------------------------------------
  // timing
  // -----------------------------------------------------------------
  localparam int CLK_HZ        = 50_000_000;
  localparam int TICK_HZ       = 1000;
  localparam int TICK_CYCLES   = CLK_HZ / TICK_HZ;
  localparam int RAMP_LIMIT_S  = 5 * 60;
  // speeds are steps/s; one tick adds speed to frac and moves at most one step (frac kept mod TICK_HZ)
  localparam logic [31:0] SPEED_RESET = 32'h000003e8;
  localparam logic [31:0] ACCEL_RESET = 32'h000003e8;
  localparam logic [31:0] DECEL_RESET = 32'h000003e8;
  localparam logic [31:0] TOP_SPEED   = 32'h000186a0;
  // smallest rate that ramps top speed within the limit, rounded up
  localparam logic [31:0] MIN_RATE =
    32'((TOP_SPEED + RAMP_LIMIT_S - 1) / RAMP_LIMIT_S);

  typedef enum logic [2:0] {
    MPBU_IDLE  = 3'b000,
    MPBU_MOVE  = 3'b001,
    MPBU_OVER  = 3'b010,
    MPBU_BACK  = 3'b011,
    MPBU_CONT  = 3'b100,
    MPBU_HALT  = 3'b101
  } mpbu_state_type;

endpackage

// File: rtl/mpbu_top.sv
// motion profile, relative targeting and backlash unit with AXI4-Lite
//
// Our own choices: the register offsets and the AXI4-Lite slave port.
`timescale 1ns/1ps

// Notes on behaviour
// - relative move: destination is reference plus delta
// - delta during position move extends destination
// - delta during run retargets from previous destination
// - reference is position of last positioning motion
// - relative move starts by command or sync
// - ramp speed up at acceleration rate
// - hold speed once required speed reached
// - decelerate to stop exactly at destination
// - short moves give triangular profile
// - acceleration and deceleration set independently
// - acceleration on by default, switchable off
// - over-long ramps flagged and clamped
// - overshoot and reapproach from selected side
// - compensation zone uses compensation speed
// - play config: enable, speed, signed distance
// - status flag while compensation active
// - forced take-up moves away then returns
// - forced take-up while moving stops smoothly
// - increasing coordinate means moving right
// - reversal negates coordinate, swaps left/right
// - limit config untouched by reversal toggle
// - maximum speed clamps ordinary motion
module mpbu_top #(
  parameter int TICK_DIV = mpbu_pkg::TICK_CYCLES
) (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // axi4-lite write address
  input  wire logic [7:0]  awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  // axi4-lite write data
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  // axi4-lite write response
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  // axi4-lite read address
  input  wire logic [7:0]  araddr,
  input  wire logic        arvalid,
  output logic             arready,
  // axi4-lite read data
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  // synchronisation input
  input  wire logic        syncPulse,
  // drive stage
  output logic             stepPulse,
  output logic             stepDir,
  output logic             playCompActiveFlag
);
  import mpbu_pkg::*;

  if (TICK_DIV < 2) begin : gBadDiv
    $error("TICK_DIV must be at least 2");
  end

  // -----------------------------------------------------------------
  // state
  // -----------------------------------------------------------------
  typedef struct packed {
    logic                 awGot;
    logic [7:0]           awAddr;
    logic                 wGot;
    logic [31:0]          wData;
    logic [3:0]           wStrb;
    logic                 bValid;
    logic [1:0]           bResp;
    logic                 rValid;
    logic [31:0]          rData;
    logic [1:0]           rResp;
    logic [31:0]          delta;
    logic [31:0]          target;
    logic [31:0]          speedReq;
    logic [31:0]          accel;
    logic [31:0]          decel;
    logic [31:0]          maxSpeed;
    logic [31:0]          playSpeed;
    logic [31:0]          playDist;
    logic [3:0]           ctrl;
    logic [31:0]          limCfg;
    logic                 badVal;
    mpbu_state_type       state;
    logic signed [31:0]   pos;
    logic signed [31:0]   dest;
    logic signed [31:0]   finalDest;
    logic                 contDir;
    logic [31:0]          speed;
    logic [31:0]          frac;
    logic [31:0]          tickCnt;
    logic                 syncPrev;
    logic                 stepOut;
    logic                 dirOut;
  } mpbu_regs_type;

  mpbu_regs_type r;
  mpbu_regs_type next_r;

  logic        tick;
  logic        wrFire;
  logic [31:0] wrMerged;
  logic [31:0] rdMux;
  logic        rdHit;
  logic        relStart;
  logic [31:0] cruise;
  logic [63:0] brakeDist;
  logic [31:0] remain;
  logic [31:0] stepAdd;
  logic        goRight;
  logic        approachRight;
  logic        inPlay;
  logic        moveRight;

  // -----------------------------------------------------------------
  // tick and helpers
  // -----------------------------------------------------------------
  // one enable pulse per profile period keeps the arithmetic in steps/s
  assign tick = (r.tickCnt == 32'(TICK_DIV - 1));

  always_comb begin
    for (int b = 0; b < 4; b++) begin
      wrMerged[8*b +: 8] = r.wStrb[b] ? r.wData[8*b +: 8] : 8'h00;
    end
  end

  assign wrFire   = r.awGot && r.wGot && !r.bValid;
  assign relStart = (wrFire && r.awAddr == ADDR_CMD
                     && r.wData[2:0] == CMD_REL_MOVE)
                    || (syncPulse && !r.syncPrev);
  assign inPlay   = (r.state == MPBU_OVER) || (r.state == MPBU_BACK);
  assign remain   = (r.pos > r.dest) ? 32'(r.pos - r.dest)
                                     : 32'(r.dest - r.pos);
  assign goRight  = (r.dest > r.pos);
  // a halt keeps the direction it had when it was ordered
  assign moveRight = (r.state == MPBU_CONT || r.state == MPBU_HALT)
                     ? r.contDir : goRight;
  // positive distance means arriving moving right (from the left side)
  assign approachRight = !r.playDist[31];

  always_comb begin
    cruise = inPlay ? r.playSpeed : r.speedReq;
    if (!inPlay && r.ctrl[CTRL_MAX_EN] && cruise > r.maxSpeed) begin
      cruise = r.maxSpeed;
    end
  end

  // distance needed to brake from current speed: v^2 / (2*dec)
  assign brakeDist = (64'(r.speed) * 64'(r.speed))
                     / (64'(r.decel) << 1);

  assign rdHit = (araddr <= ADDR_LIMCFG) && (araddr[1:0] == 2'b00);
  always_comb begin
    case (araddr)
      ADDR_DELTA:   rdMux = r.delta;
      ADDR_TARGET:  rdMux = r.target;
      ADDR_SPEED:   rdMux = r.speedReq;
      ADDR_ACCEL:   rdMux = r.accel;
      ADDR_DECEL:   rdMux = r.decel;
      ADDR_MAXSPD:  rdMux = r.maxSpeed;
      ADDR_PLAYSPD: rdMux = r.playSpeed;
      ADDR_PLAYDST: rdMux = r.playDist;
      ADDR_CTRL:    rdMux = {28'h0000000, r.ctrl};
      ADDR_STATUS:  rdMux = {28'h0000000, r.state == MPBU_CONT,
                             r.badVal, inPlay,
                             r.state != MPBU_IDLE};
      ADDR_POS:     rdMux = r.pos;
      ADDR_CURSPD:  rdMux = r.speed;
      ADDR_LIMCFG:  rdMux = r.limCfg;
      default:      rdMux = 32'h00000000;
    endcase
  end

  // -----------------------------------------------------------------
  // next state
  // -----------------------------------------------------------------
  always_comb begin
    next_r = r;
    next_r.syncPrev = syncPulse;
    next_r.stepOut  = 1'b0;
    next_r.tickCnt  = tick ? 32'h00000000 : r.tickCnt + 32'h00000001;

    // bus: address and data taken in either order
    if (awvalid && awready) begin
      next_r.awGot  = 1'b1;
      next_r.awAddr = awaddr;
    end
    if (wvalid && wready) begin
      next_r.wGot  = 1'b1;
      next_r.wData = wdata;
      next_r.wStrb = wstrb;
    end
    if (r.bValid && bready) begin
      next_r.bValid = 1'b0;
    end
    if (r.rValid && rready) begin
      next_r.rValid = 1'b0;
    end
    if (arvalid && arready) begin
      next_r.rValid = 1'b1;
      next_r.rData  = rdHit ? rdMux : 32'h00000000;
      next_r.rResp  = rdHit ? 2'b00 : 2'b10;
    end

    // profile integration on tick
    if (tick && r.state != MPBU_IDLE) begin
      if (r.state == MPBU_CONT) begin
        if (!r.ctrl[CTRL_ACCEL_EN]) begin
          next_r.speed = cruise;
        end else if (r.speed < cruise) begin
          next_r.speed = (cruise - r.speed > r.accel / 32'(TICK_HZ))
            ? r.speed + r.accel / 32'(TICK_HZ) : cruise;
        end else begin
          next_r.speed = cruise;
        end
      end else if (r.state == MPBU_HALT
                   || 64'(remain) <= brakeDist) begin
        // decelerate; triangular when this comes before cruise
        if (!r.ctrl[CTRL_ACCEL_EN]) begin
          next_r.speed = (r.state == MPBU_HALT) ? 32'h00000000 : cruise;
        end else begin
          next_r.speed = (r.speed > r.decel / 32'(TICK_HZ))
            ? r.speed - r.decel / 32'(TICK_HZ)
            : {31'h00000000, r.state != MPBU_HALT};
        end
      end else if (!r.ctrl[CTRL_ACCEL_EN]) begin
        next_r.speed = cruise;
      end else if (r.speed < cruise) begin
        next_r.speed = (cruise - r.speed > r.accel / 32'(TICK_HZ))
          ? r.speed + r.accel / 32'(TICK_HZ) : cruise;
      end else begin
        next_r.speed = cruise;
      end
      stepAdd = r.frac + r.speed;
      next_r.frac = stepAdd % 32'(TICK_HZ);
      if (stepAdd >= 32'(TICK_HZ)) begin
        next_r.stepOut = 1'b1;
        // the pin follows the shaft, so reversal flips it
        if (moveRight) begin
          next_r.pos = r.pos + 32'sd1;
          next_r.dirOut = !r.ctrl[CTRL_REVERSE];
        end else begin
          next_r.pos = r.pos - 32'sd1;
          next_r.dirOut = r.ctrl[CTRL_REVERSE];
        end
      end
      if (r.state == MPBU_HALT && next_r.speed == 32'h00000000) begin
        next_r.state = MPBU_IDLE;
        next_r.dest  = next_r.pos;
      end
      if (r.state != MPBU_CONT && r.state != MPBU_HALT
          && next_r.pos == r.dest) begin
        next_r.speed = 32'h00000000;
        next_r.frac  = 32'h00000000;
        case (r.state)
          MPBU_OVER: begin
            next_r.state = MPBU_BACK;
            next_r.dest  = r.finalDest;
          end
          default: begin
            next_r.state = MPBU_IDLE;
          end
        endcase
      end
    end else begin
      stepAdd = 32'h00000000;
    end

    // register writes and commands
    if (wrFire) begin
      next_r.awGot  = 1'b0;
      next_r.wGot   = 1'b0;
      next_r.bValid = 1'b1;
      next_r.bResp  = 2'b00;
      case (r.awAddr)
        ADDR_CMD: begin
          case (r.wData[2:0])
            CMD_ABS_MOVE: begin
              next_r.finalDest = r.target;
              next_r.dest      = r.target;
              next_r.state     = MPBU_MOVE;
            end
            CMD_SOFT_HALT, CMD_STOP: begin
              next_r.contDir = moveRight;
              next_r.state = (r.state == MPBU_IDLE) ? MPBU_IDLE
                                                    : MPBU_HALT;
            end
            CMD_PLAY_TAKE: begin
              if (r.state != MPBU_IDLE) begin
                next_r.state   = MPBU_HALT;
                next_r.contDir = moveRight;
              end else begin
                // move away by the distance, then back to start
                next_r.finalDest = r.pos;
                next_r.dest      = r.pos - $signed(r.playDist);
                next_r.state     = MPBU_OVER;
              end
            end
            CMD_RUN_RIGHT, CMD_RUN_LEFT: begin
              next_r.contDir = (r.wData[2:0] == CMD_RUN_RIGHT);
              next_r.state   = MPBU_CONT;
            end
            default: begin
              next_r.state = r.state;
            end
          endcase
        end
        ADDR_DELTA:   next_r.delta     = wrMerged;
        ADDR_TARGET:  next_r.target    = wrMerged;
        ADDR_SPEED:   next_r.speedReq  = wrMerged;
        ADDR_ACCEL, ADDR_DECEL: begin
          // ramps longer than the limit are flagged and clamped
          if (wrMerged < MIN_RATE) begin
            next_r.badVal = 1'b1;
            next_r.bResp  = 2'b10;
          end
          if (r.awAddr == ADDR_ACCEL) begin
            next_r.accel = (wrMerged < MIN_RATE) ? MIN_RATE
                                                 : wrMerged;
          end else begin
            next_r.decel = (wrMerged < MIN_RATE) ? MIN_RATE
                                                 : wrMerged;
          end
        end
        ADDR_MAXSPD:  next_r.maxSpeed  = wrMerged;
        ADDR_PLAYSPD: next_r.playSpeed = wrMerged;
        ADDR_PLAYDST: next_r.playDist  = wrMerged;
        ADDR_CTRL: begin
          next_r.ctrl = wrMerged[3:0];
          if (wrMerged[CTRL_REVERSE] != r.ctrl[CTRL_REVERSE]) begin
            // limit configuration is deliberately left alone
            next_r.pos       = -next_r.pos;
            next_r.dest      = -next_r.dest;
            next_r.finalDest = -next_r.finalDest;
            next_r.contDir   = !next_r.contDir;
          end
        end
        ADDR_STATUS:  next_r.badVal = r.badVal & ~wrMerged[STS_BAD_VAL];
        ADDR_LIMCFG:  next_r.limCfg = wrMerged;
        default:      next_r.bResp  = 2'b10;
      endcase
    end

    // relative move, by command or by sync
    if (relStart) begin
      if (r.state == MPBU_IDLE) begin
        // position after last move, zero after reset
        next_r.finalDest = r.pos + $signed(r.delta);
      end else begin
        next_r.finalDest = r.finalDest + $signed(r.delta);
      end
      next_r.state = MPBU_MOVE;
      next_r.dest  = next_r.finalDest;
    end

    // backlash: overshoot when the natural approach is the wrong one
    if (next_r.state == MPBU_MOVE && r.ctrl[CTRL_PLAY_EN]
        && next_r.finalDest != next_r.pos
        && ((next_r.finalDest > next_r.pos) != approachRight)) begin
      next_r.dest  = next_r.finalDest - $signed(r.playDist);
      next_r.state = MPBU_OVER;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      r <= '0;
      r.speedReq <= SPEED_RESET;
      r.accel    <= ACCEL_RESET;
      r.decel    <= DECEL_RESET;
      r.maxSpeed <= TOP_SPEED;
      r.playSpeed <= SPEED_RESET;
      r.ctrl     <= CTRL_RESET;
      r.state    <= MPBU_IDLE;
    end else begin
      r <= next_r;
    end
  end

  // -----------------------------------------------------------------
  // outputs
  // -----------------------------------------------------------------
  assign awready = !r.awGot && !r.bValid;
  assign wready  = !r.wGot && !r.bValid;
  assign bvalid  = r.bValid;
  assign bresp   = r.bResp;
  assign arready = !r.rValid;
  assign rvalid  = r.rValid;
  assign rdata   = r.rData;
  assign rresp   = r.rResp;
  assign stepPulse = r.stepOut;
  assign stepDir   = r.dirOut;
  assign playCompActiveFlag = inPlay;

  // -----------------------------------------------------------------
  // checks
  // -----------------------------------------------------------------
  play_flag_a: assert property (@(posedge clk) disable iff (rst)
    playCompActiveFlag == (r.state == MPBU_OVER || r.state == MPBU_BACK))
    else $error("play flag disagrees with state");
  step_right_a: assert property (@(posedge clk) disable iff (rst)
    stepPulse && $stable(r.ctrl[CTRL_REVERSE])
    |-> r.pos == $past(r.pos)
        + ((stepDir != r.ctrl[CTRL_REVERSE]) ? 32'sh1 : -32'sh1))
    else $error("step direction disagrees with position");
  ramp_bound_a: assert property (@(posedge clk) disable iff (rst)
    tick && r.ctrl[CTRL_ACCEL_EN] && r.state == MPBU_CONT
    |=> r.speed <= $past(r.speed) + $past(r.accel) / 32'(TICK_HZ))
    else $error("acceleration exceeded");
  clamp_a: assert property (@(posedge clk) disable iff (rst)
    r.accel >= MIN_RATE && r.decel >= MIN_RATE)
    else $error("ramp rate below limit");
  over_back_a: assert property (@(posedge clk) disable iff (rst)
    r.state == MPBU_OVER && next_r.state == MPBU_BACK
    |=> r.dest == r.finalDest)
    else $error("reapproach not aimed at destination");
  max_speed_a: assert property (@(posedge clk) disable iff (rst)
    r.state == MPBU_CONT && r.ctrl[CTRL_MAX_EN]
    && r.speed <= r.maxSpeed |=> r.speed <= r.maxSpeed)
    else $error("speed above maximum");
  rel_dest_a: assert property (@(posedge clk) disable iff (rst)
    relStart && r.state == MPBU_IDLE && !wrFire && !r.ctrl[CTRL_PLAY_EN]
    |=> r.dest == $past(r.pos) + $signed($past(r.delta)))
    else $error("relative destination wrong");
  reverse_a: assert property (@(posedge clk) disable iff (rst)
    r.ctrl[CTRL_REVERSE] != $past(r.ctrl[CTRL_REVERSE])
    && !$past(tick) |-> r.pos == -$past(r.pos))
    else $error("reversal did not negate position");
  tick_period_a: assert property (@(posedge clk) disable iff (rst)
    tick |=> !tick)
    else $error("tick lasted more than one cycle");

endmodule

// File: bench/mpbu_drive_model.sv
// step-counting model of the drive stage and positioner mechanics
`timescale 1ns/1ps
module mpbu_drive_model (
  // clock and reset
  input  wire logic          clk,
  input  wire logic          rst,
  // drive stage inputs
  input  wire logic          stepPulse,
  input  wire logic          stepDir,
  input  wire logic          clearTrack,
  // mechanics seen by the bench
  output logic signed [31:0] shaftPos,
  output logic signed [31:0] lowPos
);
  // lowest point shows an overshoot that the final position would hide
  always_ff @(posedge clk) begin
    if (rst) begin
      shaftPos <= '0;
      lowPos   <= '0;
    end else begin
      if (stepPulse) begin
        shaftPos <= stepDir ? shaftPos + 32'sh1 : shaftPos - 32'sh1;
      end
      if (clearTrack) begin
        lowPos <= shaftPos;
      end else if (stepPulse && !stepDir && shaftPos - 32'sh1 < lowPos) begin
        lowPos <= shaftPos - 32'sh1;
      end
    end
  end
endmodule

// File: bench/mpbu_top_tb_top.sv
// self-checking bench of the motion profile and backlash unit
`timescale 1ns/1ps
module mpbu_top_tb_top;
  import mpbu_pkg::*;
  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] data;
    logic [1:0]  resp;
  } mpbu_row_type;
  logic               clk = 1'b0, rst = 1'b1, syncPulse = 1'b0;
  logic [7:0]         awaddr = 8'h00, araddr = 8'h00;
  logic               awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic               arvalid = 1'b0, rready = 1'b0, clearTrack = 1'b0;
  logic [31:0]        wdata = 32'h0, rdata, word;
  logic [3:0]         wstrb = 4'hf;
  logic [1:0]         bresp, rresp, resp;
  logic               awready, wready, bvalid, arready, rvalid;
  logic               stepPulse, stepDir, playCompActiveFlag, flagSeen;
  logic signed [31:0] shaftPos, lowPos;
  int                 errCount = 0, checked = 0;
  mpbu_row_type       rows [8];

  always #10 clk = ~clk;
  always @(posedge clk) begin
    if (clearTrack) flagSeen <= 1'b0;
    else if (playCompActiveFlag === 1'b1) flagSeen <= 1'b1;
  end

  mpbu_top #(.TICK_DIV(4)) dut_u (.clk(clk), .rst(rst), .awaddr(awaddr),
    .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
    .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
    .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .syncPulse(syncPulse), .stepPulse(stepPulse), .stepDir(stepDir),
    .playCompActiveFlag(playCompActiveFlag));
  mpbu_drive_model model_u (.clk(clk), .rst(rst), .stepPulse(stepPulse),
    .stepDir(stepDir), .clearTrack(clearTrack), .shaftPos(shaftPos),
    .lowPos(lowPos));

  // ---------------------------------------------------------------
  // bus tasks and checks
  // ---------------------------------------------------------------
  task automatic conclude();
    $display("mismatches %0d, comparisons %0d", errCount, checked);
    if (errCount == 0 && checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic timedOut();
    errCount++;
    $display("MISMATCH %0t wait bound ran out", $time);
    conclude();
  endtask
  task automatic checkWord(input logic [31:0] got, input logic [31:0] exp,
                           input string what);
    checked++;
    if (got !== exp) begin
      errCount++;
      $display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic checkResp(input logic [1:0] got, input logic [1:0] exp,
                           input string what);
    checked++;
    if (got !== exp) begin
      errCount++;
      $display("MISMATCH %0t %s resp %h exp %h", $time, what, got, exp);
    end
  endtask
  // ready is looked at mid-cycle, where it is settled until the next edge
  task automatic axiWrite(input logic [7:0] a, input logic [31:0] d);
    int   n;
    logic awT, wT, bT;
    n = 0;
    bT = 1'b0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!bT && n < 100) begin
      @(negedge clk);
      awT = awvalid && awready;
      wT = wvalid && wready;
      bT = bvalid;
      resp = bresp;
      @(posedge clk);
      if (awT) awvalid <= 1'b0;
      if (wT) wvalid <= 1'b0;
      n++;
    end
    if (!bT) timedOut();
  endtask
  task automatic axiRead(input logic [7:0] a);
    int   n;
    logic arT, rT;
    n = 0;
    rT = 1'b0;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!rT && n < 100) begin
      @(negedge clk);
      arT = arvalid && arready;
      rT = rvalid;
      word = rdata;
      resp = rresp;
      @(posedge clk);
      if (arT) arvalid <= 1'b0;
      n++;
    end
    if (!rT) timedOut();
  endtask
  task automatic waitIdle();
    int n;
    n = 0;
    word = 32'h1;
    while (word[STS_MOVING] !== 1'b0 && n < 4000) begin
      axiRead(ADDR_STATUS);
      n++;
    end
    if (word[STS_MOVING] !== 1'b0) timedOut();
  endtask
  task automatic relMove(input logic [31:0] delta);
    axiWrite(ADDR_DELTA, delta);
    axiWrite(ADDR_CMD, {29'h0, CMD_REL_MOVE});
  endtask
  task automatic posIs(input logic [31:0] exp, input string what);
    waitIdle();
    axiRead(ADDR_POS);
    checkWord(word, exp, what);
  endtask
  task automatic startTrack();
    clearTrack <= 1'b1;
    @(posedge clk);
    clearTrack <= 1'b0;
  endtask

  initial begin
    rows[0] = '{ADDR_CTRL, 32'h1, 2'h0};
    rows[1] = '{ADDR_SPEED, SPEED_RESET, 2'h0};
    rows[2] = '{ADDR_ACCEL, ACCEL_RESET, 2'h0};
    rows[3] = '{ADDR_DECEL, DECEL_RESET, 2'h0};
    rows[4] = '{ADDR_MAXSPD, TOP_SPEED, 2'h0};
    rows[5] = '{ADDR_STATUS, 32'h0, 2'h0};
    rows[6] = '{ADDR_POS, 32'h0, 2'h0};
    rows[7] = '{8'h3c, 32'h0, 2'h2};
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    foreach (rows[i]) begin
      axiRead(rows[i].addr);
      checkWord(word, rows[i].data, "reset value");
      checkResp(resp, rows[i].resp, "reset access");
    end
    axiWrite(8'h3c, 32'h1);
    checkResp(resp, 2'h2, "unmapped write");
    axiWrite(ADDR_POS, 32'h7);
    checkResp(resp, 2'h2, "read-only write");
    // too gentle a ramp is refused and clamped, then a fast one restored
    axiWrite(ADDR_ACCEL, 32'h1);
    checkResp(resp, 2'h2, "slow ramp refused");
    axiRead(ADDR_ACCEL);
    checkWord(word, MIN_RATE, "ramp clamped");
    axiRead(ADDR_STATUS);
    checkWord({31'h0, word[STS_BAD_VAL]}, 32'h1, "bad value flag");
    axiWrite(ADDR_STATUS, 32'h4);
    axiWrite(ADDR_ACCEL, 32'h186a0);
    axiWrite(ADDR_DECEL, 32'hc350);
    axiRead(ADDR_DECEL);
    checkWord(word, 32'hc350, "decel kept apart");
    relMove(32'ha);
    posIs(32'ha, "first relative");
    checkWord(shaftPos, 32'ha, "shaft steps");
    relMove(32'hfffffffc);
    posIs(32'h6, "from last reached");
    relMove(32'h14);
    relMove(32'h5);
    posIs(32'h1f, "retarget in motion");
    axiWrite(ADDR_DELTA, 32'h3);
    syncPulse <= 1'b1;
    repeat (3) @(posedge clk);
    syncPulse <= 1'b0;
    posIs(32'h22, "sync relative");
    axiWrite(ADDR_PLAYSPD, 32'h3e8);
    axiWrite(ADDR_PLAYDST, 32'h5);
    axiWrite(ADDR_CTRL, 32'h3);
    startTrack();
    relMove(32'hfffffff6);
    posIs(32'h18, "approach from left");
    checkWord(lowPos, 32'h13, "overshoot depth");
    checkWord({31'h0, flagSeen}, 32'h1, "play flag");
    startTrack();
    axiWrite(ADDR_CMD, {29'h0, CMD_PLAY_TAKE});
    posIs(32'h18, "take-up returns");
    checkWord(lowPos, 32'h13, "take-up travel");
    checkWord({31'h0, flagSeen}, 32'h1, "take-up flag");
    axiWrite(ADDR_LIMCFG, 32'h5);
    axiWrite(ADDR_CTRL, 32'h7);
    axiRead(ADDR_POS);
    checkWord(word, 32'hffffffe8, "reversed sign");
    axiRead(ADDR_LIMCFG);
    checkWord(word, 32'h5, "limits kept");
    relMove(32'h4);
    posIs(32'hffffffec, "reversed move");
    checkWord(shaftPos, 32'h14, "reversed shaft");
    // capped run, retarget from the old destination, ramped halt
    axiWrite(ADDR_SPEED, 32'h7d0);
    axiWrite(ADDR_MAXSPD, 32'h3e8);
    axiWrite(ADDR_CTRL, 32'hb);
    axiWrite(ADDR_CMD, {29'h0, CMD_RUN_RIGHT});
    repeat (100) @(posedge clk);
    axiRead(ADDR_CURSPD);
    checkWord(word, 32'h3e8, "run capped");
    relMove(32'h64);
    posIs(32'h78, "retarget in run");
    axiWrite(ADDR_CMD, {29'h0, CMD_RUN_LEFT});
    repeat (100) @(posedge clk);
    axiWrite(ADDR_CMD, {29'h0, CMD_PLAY_TAKE});
    axiRead(ADDR_CURSPD);
    checkWord({31'h0, word != 32'h0}, 32'h1, "halt ramps");
    waitIdle();
    axiRead(ADDR_CURSPD);
    checkWord(word, 32'h0, "halted");
    axiWrite(ADDR_TARGET, 32'h64);
    axiWrite(ADDR_CMD, {29'h0, CMD_ABS_MOVE});
    posIs(32'h64, "absolute move");
    axiRead(ADDR_POS);
    checkWord(word, shaftPos, "shaft follows position");
    conclude();
  end
endmodule
